// File: core/bsdpm_pkg.sv
// package: constants and types for the boot select and debug pin mux
package bsdpm_pkg;

  // ****************************************
  // pin inputs and synchroniser
  // ****************************************
  localparam int unsigned SYNC_W      = 5;        // four port pins plus reset pin
  localparam int unsigned IDX_BIT0    = 0;        // trst / boot select / gpio
  localparam int unsigned IDX_TDO     = 1;        // tdo / gpio
  localparam int unsigned IDX_TDI     = 2;        // tdi / gpio
  localparam int unsigned IDX_TCK     = 3;        // tck / gpio
  localparam int unsigned IDX_RST_PIN = 4;        // external reset pin
  localparam logic [4:0]  SYNC_RST_VAL = 5'h00;   // reset pin seen low until synced

  // ****************************************
  // boot decision
  // ****************************************
  localparam logic [23:0] FLASH_BOOT_ADDR = 24'h800014;
  localparam logic [31:0] FLASH_BLANK     = 32'hFFFFFFFF;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [3:0] P0_OUT_RST  = 4'h0;
  localparam logic [3:0] P0_OE_N_RST = 4'hF;      // all pins released
  localparam logic       FLAG_RST    = 1'h0;
  localparam logic       JTAG_RST_RST = 1'h1;     // debug port held in reset

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [2:0]
  {
    BSDPM_RESET  = 3'h1,
    BSDPM_SAMPLE = 3'h2,
    BSDPM_RUN    = 3'h4
  } bsdpm_state_type;

endpackage : bsdpm_pkg

// File: core/bsdpm_sync.sv
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module bsdpm_sync
  import bsdpm_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  bsdpm_sync_if.sync_side   sif
);

  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] stable_q;
  logic [SYNC_W-1:0] stable_d;

  // ****************************************
  // filter
  // ****************************************
  // a bit changes only when stages two and three agree
  assign stable_d   = (s2_q & s3_q) | (stable_q & (s2_q ^ s3_q));
  assign sif.stable = stable_q;

  // shift chain, first stage read only by the second
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1_q     <= SYNC_RST_VAL;
      s2_q     <= SYNC_RST_VAL;
      s3_q     <= SYNC_RST_VAL;
      stable_q <= SYNC_RST_VAL;
    end
    else
    begin
      s1_q     <= sif.raw;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      stable_q <= stable_d;
    end
  end

endmodule : bsdpm_sync

`default_nettype wire

// File: core/bsdpm_sync_if.sv
// interface: raw pin levels in, filtered levels out
`timescale 1ns/10ps
`default_nettype none

interface bsdpm_sync_if;
  import bsdpm_pkg::*;

  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] stable;

  modport sync_side (input raw, output stable);
  modport core_side (output raw, input stable);

endinterface : bsdpm_sync_if

`default_nettype wire

// File: core/bsdpm_top.sv
// module: boot mode selection and port-0 debug pin multiplexer
`timescale 1ns/10ps
`default_nettype none

// How it works
// - boot select low at reset with the boot flash word all ones selects serial download mode.
// - boot select high, or low with a flash word not all ones, selects user code execution.
// - port bit 1 comes up as gpio input for boot select 0 and as test data out for 1.
// - port bit 2 comes up as gpio input for boot select 0 and as test data in for 1.
// - port bit 3 comes up as gpio input for boot select 0 and as test clock in for 1.
// - a low test reset holds the debug port in reset and gives bits 1 to 3 back to gpio.
// - the external reset pin is active low and holds the block in reset while low.
// - the returned test clock is an output driven from the debug port logic.
// - port bit 0 is gpio after reset.
module bsdpm_top
  import bsdpm_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_RST_N,
  input  wire logic [3:0]  I_P0_IN,
  output logic      [3:0]  O_P0_OUT,
  output logic      [3:0]  O_P0_OE_N,
  input  wire logic [3:0]  I_GPIO_OUT,
  input  wire logic [3:0]  I_GPIO_OE,
  output logic      [3:0]  O_GPIO_IN,
  input  wire logic [31:0] I_FLASH_WORD,
  output logic      [23:0] O_FLASH_ADDR,
  output logic             O_DOWNLOAD_MODE,
  output logic             O_RUN_USER,
  output logic             O_JTAG_MODE,
  output logic             O_JTAG_RST,
  output logic             O_JTAG_TCK,
  output logic             O_JTAG_TDI,
  input  wire logic        I_JTAG_TDO,
  output logic             O_RETURNED_TEST_CLOCK
);

  // ****************************************
  // pin synchroniser
  // ****************************************
  bsdpm_sync_if sif ();

  assign sif.raw = {I_RST_N, I_P0_IN};

  bsdpm_sync u_sync
  (
    .i_clk (I_CLK),
    .i_rst (I_SYS_RST),
    .sif   (sif.sync_side)
  );

  // ****************************************
  // declarations
  // ****************************************
  bsdpm_state_type state_q;
  bsdpm_state_type state_d;
  logic            rst_any;
  logic            boot_sel;
  logic            flash_blank;
  logic            jtag_mode_q;
  logic            dl_mode_q;
  logic            run_user_q;
  logic            jtag_act;
  logic            in_run;
  logic [3:0]      p0_out_d;
  logic [3:0]      p0_oe_n_d;
  logic [3:0]      p0_out_q;
  logic [3:0]      p0_oe_n_q;
  logic [3:0]      gpio_in_q;
  logic            tck_q;
  logic            tdi_q;
  logic            returned_test_clock_q;
  logic            jtag_rst_q;

  // ****************************************
  // reset and boot decode
  // ****************************************
  // pin reset is active low, merged with system reset
  assign rst_any     = I_SYS_RST | ~sif.stable[IDX_RST_PIN];
  assign boot_sel    = sif.stable[IDX_BIT0];
  assign flash_blank = (I_FLASH_WORD == FLASH_BLANK);
  assign in_run      = (state_q == BSDPM_RUN);

  // debug port live only in jtag mode with test reset high
  assign jtag_act = in_run & jtag_mode_q & sif.stable[IDX_BIT0];

  // ****************************************
  // sequencer
  // ****************************************
  // reset -> one sample cycle -> run until next reset
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      BSDPM_RESET:  state_d = BSDPM_SAMPLE;
      BSDPM_SAMPLE: state_d = BSDPM_RUN;
      BSDPM_RUN:    state_d = BSDPM_RUN;
      default:      state_d = BSDPM_RESET;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (rst_any)
      state_q <= BSDPM_RESET;
    else
      state_q <= state_d;
  end

  // captured once on the sample cycle
  always_ff @(posedge I_CLK)
  begin
    if (rst_any)
    begin
      jtag_mode_q <= FLAG_RST;
      dl_mode_q   <= FLAG_RST;
      run_user_q  <= FLAG_RST;
    end
    else if (state_q == BSDPM_SAMPLE)
    begin
      jtag_mode_q <= boot_sel;
      dl_mode_q   <= ~boot_sel & flash_blank;
      run_user_q  <= boot_sel | ~flash_blank;
    end
  end

  // ****************************************
  // pin multiplexer
  // ****************************************
  // bit 0 always gpio; bit 1 drives tdo; bits 2, 3 are inputs in jtag
  assign p0_out_d[0]  = in_run & I_GPIO_OUT[0];
  assign p0_oe_n_d[0] = ~(in_run & I_GPIO_OE[0]);
  assign p0_out_d[1]  = jtag_act ? I_JTAG_TDO : in_run & I_GPIO_OUT[1];
  assign p0_oe_n_d[1] = jtag_act ? 1'b0 : ~(in_run & I_GPIO_OE[1]);
  assign p0_out_d[2]  = ~jtag_act & in_run & I_GPIO_OUT[2];
  assign p0_oe_n_d[2] = jtag_act | ~(in_run & I_GPIO_OE[2]);
  assign p0_out_d[3]  = ~jtag_act & in_run & I_GPIO_OUT[3];
  assign p0_oe_n_d[3] = jtag_act | ~(in_run & I_GPIO_OE[3]);

  always_ff @(posedge I_CLK)
  begin
    if (rst_any)
    begin
      p0_out_q  <= P0_OUT_RST;
      p0_oe_n_q <= P0_OE_N_RST;
      gpio_in_q <= P0_OUT_RST;
    end
    else
    begin
      p0_out_q  <= p0_out_d;
      p0_oe_n_q <= p0_oe_n_d;
      gpio_in_q <= sif.stable[3:0];
    end
  end

  // ****************************************
  // debug port signals
  // ****************************************
  // clock and data gated off while test reset is low
  // debug reset is a flop too, so a low test reset in jtag mode still resets
  always_ff @(posedge I_CLK)
  begin
    if (rst_any)
    begin
      tck_q      <= FLAG_RST;
      tdi_q      <= FLAG_RST;
      returned_test_clock_q     <= FLAG_RST;
      jtag_rst_q <= JTAG_RST_RST;
    end
    else
    begin
      tck_q      <= jtag_act & sif.stable[IDX_TCK];
      tdi_q      <= jtag_act & sif.stable[IDX_TDI];
      returned_test_clock_q     <= jtag_act & sif.stable[IDX_TCK];
      jtag_rst_q <= ~jtag_act;
    end
  end

  assign O_P0_OUT        = p0_out_q;
  assign O_P0_OE_N       = p0_oe_n_q;
  assign O_GPIO_IN       = gpio_in_q;
  assign O_FLASH_ADDR    = FLASH_BOOT_ADDR;
  assign O_DOWNLOAD_MODE = dl_mode_q;
  assign O_RUN_USER      = run_user_q;
  assign O_JTAG_MODE     = jtag_mode_q;
  assign O_JTAG_RST      = jtag_rst_q;
  assign O_JTAG_TCK      = tck_q;
  assign O_JTAG_TDI      = tdi_q;
  assign O_RETURNED_TEST_CLOCK          = returned_test_clock_q;

  // ****************************************
  // assertions
  // ****************************************
  property p_download;
    @(posedge I_CLK) disable iff (rst_any)
    (state_q == BSDPM_SAMPLE && !boot_sel && flash_blank) |=> O_DOWNLOAD_MODE && !O_RUN_USER;
  endproperty
  a_download: assert property (p_download) else $error("download mode not entered");

  property p_run_user;
    @(posedge I_CLK) disable iff (rst_any)
    (state_q == BSDPM_SAMPLE && (boot_sel || !flash_blank)) |=> O_RUN_USER && !O_DOWNLOAD_MODE;
  endproperty
  a_run_user: assert property (p_run_user) else $error("user code not selected");

  property p_tdo;
    @(posedge I_CLK) disable iff (rst_any)
    jtag_act |=> !O_P0_OE_N[1] && O_P0_OUT[1] == $past(I_JTAG_TDO);
  endproperty
  a_tdo: assert property (p_tdo) else $error("tdo not driven on bit 1");

  property p_tdi;
    @(posedge I_CLK) disable iff (rst_any)
    jtag_act |=> O_P0_OE_N[2] && O_JTAG_TDI == $past(sif.stable[IDX_TDI]);
  endproperty
  a_tdi: assert property (p_tdi) else $error("tdi not taken from bit 2");

  property p_tck;
    @(posedge I_CLK) disable iff (rst_any)
    jtag_act |=> O_P0_OE_N[3] && O_JTAG_TCK == $past(sif.stable[IDX_TCK]);
  endproperty
  a_tck: assert property (p_tck) else $error("tck not taken from bit 3");

  property p_trst;
    @(posedge I_CLK) disable iff (rst_any)
    (in_run && !sif.stable[IDX_BIT0]) |=> O_JTAG_RST && !O_JTAG_TCK
      && O_P0_OE_N[1] == !$past(I_GPIO_OE[1]);
  endproperty
  a_trst: assert property (p_trst) else $error("debug port not released to gpio");

  property p_pin_reset;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    !sif.stable[IDX_RST_PIN] |=> state_q == BSDPM_RESET && !O_RUN_USER && O_P0_OE_N == 4'hF;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("low reset pin not honoured");

  property p_returned_test_clock;
    @(posedge I_CLK) disable iff (rst_any)
    jtag_act |=> O_RETURNED_TEST_CLOCK == $past(sif.stable[IDX_TCK]);
  endproperty
  a_returned_test_clock: assert property (p_returned_test_clock) else $error("returned clock not following tck");

  property p_bit0;
    @(posedge I_CLK) disable iff (rst_any)
    in_run |=> O_P0_OE_N[0] == !$past(I_GPIO_OE[0]) && O_P0_OUT[0] == $past(I_GPIO_OUT[0]);
  endproperty
  a_bit0: assert property (p_bit0) else $error("bit 0 not gpio");

  property p_hold;
    @(posedge I_CLK) disable iff (rst_any)
    (in_run && $past(in_run)) |-> $stable(jtag_mode_q) && $stable(O_DOWNLOAD_MODE);
  endproperty
  a_hold: assert property (p_hold) else $error("boot decision changed after sampling");

endmodule : bsdpm_top

`default_nettype wire

// File: tb/bsdpm_probe.sv
// model: debug probe and board strap levels
`timescale 1ns/10ps
`default_nettype none
module bsdpm_probe
(
  input  wire logic       i_clk,
  input  wire logic       i_strap,
  input  wire logic       i_active,
  input  wire logic       i_tdi,
  output logic      [3:0] o_ext,
  output logic            o_tck
);
  logic [1:0] div_q = 2'h0;
  logic       tck_q = 1'h0;
  logic       idle_q = 1'h0;
  // tck toggles every four cycles in a session, stands low outside
  always @(posedge i_clk)
  begin
    div_q  <= i_active ? div_q + 2'h1 : 2'h0;
    tck_q  <= i_active & (tck_q ^ (div_q == 2'h3));
    idle_q <= ~idle_q;
  end
  // released tdo line changes every cycle, never holds
  assign o_ext = {tck_q, i_tdi, idle_q, i_strap};
  assign o_tck = tck_q;
endmodule : bsdpm_probe
`default_nettype wire

// File: tb/bsdpm_top_tb_top.sv
// bench: boot mode and debug pin mux checks
`timescale 1ns/10ps
`default_nettype none
module bsdpm_top_tb_top;
  import bsdpm_pkg::*;
  logic        clk = 1'h0, rst = 1'h1, rst_n = 1'h1, tdo = 1'h0;
  logic        strap = 1'h0, active = 1'h0, tdi = 1'h0;
  logic [3:0]  gout = 4'h0, goe = 4'h0;
  logic [31:0] flash = 32'h0;
  logic [3:0]  pins, out, oe_n, gin, ext;
  logic [23:0] faddr;
  logic        dl, run, jmode, jrst, jtck, jtdi, returned_test_clock, ptck;
  int          errors = 0, compares = 0, cycles = 0;
  always #2 clk = ~clk;
  // a pin shows the device level while it drives, else the far side
  assign pins = (oe_n & ext) | (~oe_n & out);
  bsdpm_top dut_u (.I_CLK(clk), .I_SYS_RST(rst), .I_RST_N(rst_n), .I_P0_IN(pins),
    .O_P0_OUT(out), .O_P0_OE_N(oe_n), .I_GPIO_OUT(gout), .I_GPIO_OE(goe),
    .O_GPIO_IN(gin), .I_FLASH_WORD(flash), .O_FLASH_ADDR(faddr),
    .O_DOWNLOAD_MODE(dl), .O_RUN_USER(run), .O_JTAG_MODE(jmode), .O_JTAG_RST(jrst),
    .O_JTAG_TCK(jtck), .O_JTAG_TDI(jtdi), .I_JTAG_TDO(tdo), .O_RETURNED_TEST_CLOCK(returned_test_clock));
  bsdpm_probe probe_u (.i_clk(clk), .i_strap(strap), .i_active(active), .i_tdi(tdi),
    .o_ext(ext), .o_tck(ptck));
  // ************************
  // helpers
  // ************************
  task automatic final_report();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'h1)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic boot(input logic bs, input logic [31:0] fw);
    tick(1);
    strap <= bs;
    flash <= fw;
    rst   <= 1'h1;
    tick(4);
    rst   <= 1'h0;
    tick(16);
  endtask : boot
  // ************************
  // scenarios
  // ************************
  task automatic t_boot();
    logic [31:0] fw [4] = '{FLASH_BLANK, 32'hFFFFFFFE, FLASH_BLANK, 32'h0};
    logic        e;
    for (int i = 0; i < 4; i++)
    begin
      e = (i == 0);
      boot(i[1], fw[i]);
      chk(faddr === FLASH_BOOT_ADDR, "flash address");
      chk(dl === e, "download mode");
      chk(run === !e, "run user");
      chk(jmode === i[1], "debug mode");
      strap <= ~i[1];
      flash <= ~fw[i];
      tick(12);
      chk({dl, run, jmode} === {e, !e, i[1]}, "modes held");
    end
  endtask : t_boot
  task automatic t_gpio();
    logic [3:0] pat [3] = '{4'h3, 4'hC, 4'hF};
    boot(1'h0, 32'h0);
    foreach (pat[i])
    begin
      goe  <= pat[i];
      gout <= pat[i] ^ 4'h5;
      tick(4);
      chk(oe_n === ~pat[i], "gpio enables");
      chk((out & pat[i]) === ((pat[i] ^ 4'h5) & pat[i]), "gpio data");
      chk({jrst, jtck, jtdi} === 3'h4, "debug idle");
    end
    goe <= 4'h0;
    tdi <= 1'h1;
    tick(8);
    chk(gin[2] === 1'h1, "gpio input");
    tdi <= 1'h0;
  endtask : t_gpio
  task automatic t_jtag();
    int   nj, nr, np;
    logic lj, lr, lp;
    boot(1'h1, FLASH_BLANK);
    active <= 1'h1;
    tdi    <= 1'h1;
    tdo    <= 1'h1;
    tick(8);
    chk(oe_n[3:1] === 3'h6 && out[1] === 1'h1, "tdo drive");
    chk(jtdi === 1'h1 && jrst === 1'h0, "tdi in");
    tdi <= 1'h0;
    tdo <= 1'h0;
    {nj, nr, np} = '0;
    {lj, lr, lp} = {jtck, returned_test_clock, ptck};
    for (int k = 0; k < 64; k++)
    begin
      tick(1);
      nj += int'(jtck !== lj);
      nr += int'(returned_test_clock !== lr);
      np += int'(ptck !== lp);
      {lj, lr, lp} = {jtck, returned_test_clock, ptck};
    end
    chk(out[1] === 1'h0 && jtdi === 1'h0, "tdo tdi low");
    chk(np > 8 && nj >= np - 1 && nj <= np + 1, "tck follows");
    chk(nr >= np - 1 && nr <= np + 1, "returned_test_clock follows");
  endtask : t_jtag
  task automatic t_trst();
    strap <= 1'h0;
    goe   <= 4'hE;
    gout  <= 4'h6;
    tick(10);
    chk(jrst === 1'h1 && jtck === 1'h0 && returned_test_clock === 1'h0, "debug held");
    chk(oe_n[3:1] === 3'h0 && out[3:1] === 3'h3, "pins to gpio");
    chk(jmode === 1'h1, "mode kept");
    strap <= 1'h1;
    goe   <= 4'h0;
    tick(10);
    chk(jrst === 1'h0 && oe_n[3:1] === 3'h6, "debug back");
  endtask : t_trst
  task automatic t_rstpin();
    rst_n <= 1'h0;
    tick(8);
    chk({dl, run, jmode, jrst} === 4'h1, "held in reset");
    chk(oe_n === 4'hF, "pins released");
    rst_n <= 1'h1;
    tick(12);
    chk({run, jmode, jrst} === 3'h6, "resampled");
    active <= 1'h0;
  endtask : t_rstpin
  // main sequence
  initial
  begin
    t_boot();
    t_gpio();
    t_jtag();
    t_trst();
    t_rstpin();
    final_report();
  end
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      final_report();
    end
  end
endmodule : bsdpm_top_tb_top
`default_nettype wire
